// File: hdl/vpr_pkg.sv
// constants, carriers and helpers shared by the voltage-mode amplitude regulator
package vpr_pkg;

    // chopper period in half clock cycles, one per frequency code
    localparam logic [10:0] CHOP_HALF_00 = 11'h400;
    localparam logic [10:0] CHOP_HALF_01 = 11'h2AB;
    localparam logic [10:0] CHOP_HALF_10 = 11'h200;
    localparam logic [10:0] CHOP_HALF_11 = 11'h19A;
    localparam logic [10:0] CHOP_HALF_INC = 11'h002;

    // blanking interval in clock cycles, one per blank code
    localparam logic [5:0]  BLANK_00 = 6'h10;
    localparam logic [5:0]  BLANK_01 = 6'h18;
    localparam logic [5:0]  BLANK_10 = 6'h20;
    localparam logic [5:0]  BLANK_11 = 6'h28;

    localparam logic [7:0]  AMP_MAX      = 8'hFF;
    localparam logic [7:0]  AMP_MIN_REG  = 8'h01;
    localparam logic [7:0]  SINE_PEAK    = 8'hF8;
    localparam int          VEL_SHIFT    = 8;
    localparam int          GAIN_SHIFT   = 3;
    localparam logic [2:0]  FS_PER_GRAD  = 3'h7;
    localparam logic [7:0]  LEARN_OFS_RST  = 8'h24;
    localparam logic [7:0]  LEARN_GRAD_RST = 8'h0E;
    localparam logic signed [9:0] SCALE_POS_MAX = 10'sh0FF;
    localparam logic signed [9:0] SCALE_NEG_MAX = -10'sh0FF;

    typedef struct packed {
        logic       autoscale_en;
        logic       autograd_en;
        logic       freewheel_en;
        logic [1:0] chopper_frequency_select;
        logic [1:0] blank_time_select;
        logic [7:0] regulator_gain;
        logic [7:0] manual_amplitude_offset;
        logic [7:0] manual_velocity_gradient;
    } vpr_cfg_t;

    typedef struct packed {
        logic [7:0] total_drive_amplitude;
        logic [7:0] learned_offset;
        logic [7:0] learned_gradient;
        logic [7:0] sine_peak;
        logic       amplitude_saturated;
        logic       regulating;
    } vpr_status_t;

    function automatic logic [10:0] chop_half(input logic [1:0] sel);
        case (sel)
            2'h0:    chop_half = CHOP_HALF_00;
            2'h1:    chop_half = CHOP_HALF_01;
            2'h2:    chop_half = CHOP_HALF_10;
            default: chop_half = CHOP_HALF_11;
        endcase
    endfunction

    function automatic logic [5:0] blank_cycles(input logic [1:0] sel);
        case (sel)
            2'h0:    blank_cycles = BLANK_00;
            2'h1:    blank_cycles = BLANK_01;
            2'h2:    blank_cycles = BLANK_10;
            default: blank_cycles = BLANK_11;
        endcase
    endfunction

    // saturate a signed sum into the 8-bit amplitude range
    function automatic logic [7:0] clamp_u8(input logic signed [19:0] v);
        if (v < 20'sh0) begin
            clamp_u8 = 8'h00;
        end else if (v > 20'sh000FF) begin
            clamp_u8 = AMP_MAX;
        end else begin
            clamp_u8 = v[7:0];
        end
    endfunction

endpackage

// File: hdl/vpr_chop_timer.sv
// chopper period generator with blanked on-phase current sample strobe
`timescale 1ns/1ps
module vpr_chop_timer (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] freq_sel,
    input  wire logic [1:0] blank_sel,
    input  wire logic [7:0] duty,
    output logic            pwm_on,
    output logic            period_start,
    output logic            sample_stb
);
    logic [10:0] acc;
    logic [10:0] next_acc;
    logic [5:0]  on_cnt;
    logic [5:0]  next_on_cnt;
    logic        sampled;
    logic        next_sampled;
    logic [10:0] half;
    logic [5:0]  blank;
    logic [18:0] thr;
    logic [11:0] acc_sum;
    logic [1:0]  samples_seen;
    logic [1:0]  next_samples_seen;

    always_comb begin
        half         = vpr_pkg::chop_half(freq_sel);
        blank        = vpr_pkg::blank_cycles(blank_sel);
        thr          = 19'(duty) * 19'(half);
        acc_sum      = 12'(acc) + 12'(vpr_pkg::CHOP_HALF_INC);
        period_start = acc_sum >= 12'(half);
        // fractional period: stepping by two half cycles gives 2/N of the clock  RQ16
        next_acc     = period_start ? 11'(acc_sum - 12'(half)) : acc_sum[10:0];
        pwm_on       = 11'(acc) < thr[18:8];
        sample_stb   = pwm_on && !sampled && on_cnt == blank - 6'h01;  // RQ5
        next_on_cnt  = period_start ? 6'h00 : (pwm_on && on_cnt != 6'h3F ? on_cnt + 6'h01 : on_cnt);
        next_sampled = period_start ? 1'b0 : (sampled | sample_stb);  // RQ19
        // strobe count per period, kept only for the check below
        next_samples_seen = period_start ? 2'h0 : samples_seen + {1'b0, sample_stb && samples_seen != 2'h3};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc     <= 11'h000;
            on_cnt  <= 6'h00;
            sampled <= 1'b0;
            samples_seen <= 2'h0;
        end else begin
            acc     <= next_acc;
            on_cnt  <= next_on_cnt;
            sampled <= next_sampled;
            samples_seen <= next_samples_seen;
        end
    end

    a_blank_before_sample: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ5
        sample_stb |-> pwm_on && on_cnt == blank - 6'h01)
        else $error("current sampled before blanking ended");

    a_one_sample_period: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ19
        sample_stb |-> samples_seen == 2'h0)
        else $error("second current sample within one chopper period");

endmodule

// File: hdl/vpr_regulator.sv
// voltage-mode chopper amplitude: current regulator and velocity feed-forward
// Requirements this block is written to
// RQ1: both automatic enables set means regulate coil current toward target.
// RQ2: sample current in on phase; proportional step, gain from regulator setting.
// RQ3: during tuning phase two the regulator also absorbs velocity changes.
// RQ4: software keeps regulator gain small, sized for fastest ramp.
// RQ5: current visible only after blanking in on phase; short duty stops regulation.
// RQ6: lower currents come from offset and gradient, learned or manual.
// RQ7: zero amplitude only with freewheel; regulated path floors above zero.
// RQ8: software keeps run current above limit until tuning completes.
// RQ9: software keeps run scale 8 to 31, uses sense range instead.
// RQ10: automatic amplitude off: amplitude from step interval, no feedback.
// RQ11: velocity mode selected only by serial configuration, never by straps.
// RQ12: total equals offset plus gradient times 256 over step interval.
// RQ13: 8-bit amplitude, sine peak 248; coil voltage is supply times amplitude/374.
// RQ14: learned offset and gradient readable for reuse as manual values.
// RQ15: lower limit also bounds following reference-input current reductions.
// RQ16: frequency code selects 2/1024, 2/683, 2/512, 2/410 of clock.
// RQ17: total amplitude saturates at 255 and flags it.
// RQ18: software starts tuning phase one at standstill with run scale.
// RQ19: learned amplitude updates at most once per chopper period.
// RQ20: total amplitude clamped to 0..255 before driving sine output.
`timescale 1ns/1ps
module vpr_regulator (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire vpr_pkg::vpr_cfg_t    cfg,
    input  wire logic [7:0]           target_current,
    input  wire logic [7:0]           coil_current,
    input  wire logic [19:0]          step_interval_measure,
    input  wire logic                 tuning_phase_one,
    input  wire logic                 tuning_phase_two,
    input  wire logic                 fullstep_pulse,
    output logic                      pwm_on,
    output vpr_pkg::vpr_status_t      status
);
    typedef enum logic [4:0] {
        VPR_ST_FF     = 5'b00001,
        VPR_ST_REG    = 5'b00010,
        VPR_ST_PH1    = 5'b00100,
        VPR_ST_PH2    = 5'b01000,
        VPR_ST_FROZEN = 5'b10000
    } vpr_state_t;

    vpr_state_t         state;
    vpr_state_t         next_state;
    logic signed [9:0]  scale_auto;
    logic signed [9:0]  next_scale_auto;
    logic [7:0]         learned_offset;
    logic [7:0]         next_learned_offset;
    logic [7:0]         learned_gradient;
    logic [7:0]         next_learned_gradient;
    logic [2:0]         fs_cnt;
    logic [2:0]         next_fs_cnt;
    logic [15:0]        vel_term;
    logic [15:0]        next_vel_term;
    logic [7:0]         total;
    logic [7:0]         next_total;
    logic [7:0]         peak;
    logic [7:0]         next_peak;
    logic               saturated;
    logic               next_saturated;
    logic               period_start;
    logic               sample_stb;
    logic               auto_mode;
    logic               freewheel_zero;
    logic signed [8:0]  err;
    logic signed [17:0] prod;
    logic signed [9:0]  delta;
    logic [7:0]         ofs_used;
    logic [7:0]         grad_used;
    logic signed [19:0] sum;
    logic [15:0]        peak_prod;

    // wide input: full error times gain 255 does not fit eleven bits
    function automatic logic signed [9:0] sat_scale(input logic signed [18:0] v);
        if (v > 19'(vpr_pkg::SCALE_POS_MAX)) begin
            sat_scale = vpr_pkg::SCALE_POS_MAX;
        end else if (v < 19'(vpr_pkg::SCALE_NEG_MAX)) begin
            sat_scale = vpr_pkg::SCALE_NEG_MAX;
        end else begin
            sat_scale = v[9:0];
        end
    endfunction

    function automatic logic [7:0] step_u8(input logic [7:0] v, input logic signed [9:0] dir);
        if (dir > 10'sh0 && v != vpr_pkg::AMP_MAX) begin
            step_u8 = v + 8'h01;
        end else if (dir < 10'sh0 && v != 8'h00) begin
            step_u8 = v - 8'h01;
        end else begin
            step_u8 = v;
        end
    endfunction

    vpr_chop_timer u_chop (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .freq_sel     (cfg.chopper_frequency_select),
        .blank_sel    (cfg.blank_time_select),
        .duty         (total),
        .pwm_on       (pwm_on),
        .period_start (period_start),
        .sample_stb   (sample_stb)
    );

    // mode selection: only the configuration fields pick velocity mode
    always_comb begin
        auto_mode      = cfg.autoscale_en && cfg.autograd_en;  // RQ1 RQ11
        freewheel_zero = cfg.freewheel_en && target_current == 8'h00;  // RQ7
        if (!auto_mode) begin
            next_state = VPR_ST_FF;  // RQ10
        end else if (freewheel_zero) begin
            // hold the loop so a restart begins from the last good amplitude
            next_state = VPR_ST_FROZEN;
        end else if (tuning_phase_one) begin
            next_state = VPR_ST_PH1;
        end else if (tuning_phase_two) begin
            next_state = VPR_ST_PH2;
        end else begin
            next_state = VPR_ST_REG;
        end
    end

    // proportional loop, fed only by the blanked on-phase sample
    always_comb begin
        err                   = 9'(target_current) - 9'(coil_current);
        prod                  = 18'(err) * $signed({10'h000, cfg.regulator_gain});  // RQ2
        delta                 = sat_scale(19'(prod >>> vpr_pkg::GAIN_SHIFT));
        next_scale_auto       = scale_auto;
        next_learned_offset   = learned_offset;
        next_learned_gradient = learned_gradient;
        next_fs_cnt           = fs_cnt;
        case (state)
            VPR_ST_FF: begin
                next_scale_auto = 10'sh000;
                next_fs_cnt     = 3'h0;
            end
            VPR_ST_REG: begin
                if (sample_stb) begin
                    next_scale_auto = sat_scale(19'(scale_auto) + 19'(delta));  // RQ2 RQ19 RQ15
                end
            end
            VPR_ST_PH1: begin
                // standstill: the error belongs to the offset
                if (sample_stb) begin
                    next_learned_offset = step_u8(learned_offset, delta);  // RQ6
                end
            end
            VPR_ST_PH2: begin
                if (sample_stb) begin
                    next_scale_auto = sat_scale(19'(scale_auto) + 19'(delta));  // RQ3
                end
                if (fullstep_pulse) begin
                    next_fs_cnt = fs_cnt + 3'h1;
                    if (fs_cnt == vpr_pkg::FS_PER_GRAD) begin
                        next_learned_gradient = step_u8(learned_gradient, scale_auto);  // RQ3
                    end
                end
            end
            VPR_ST_FROZEN: begin
                next_scale_auto = scale_auto;
            end
            default: begin
                next_scale_auto = 10'sh000;
            end
        endcase
    end

    // amplitude path: offset plus gradient times 256 over step interval
    always_comb begin
        ofs_used  = auto_mode ? learned_offset : cfg.manual_amplitude_offset;  // RQ6
        grad_used = auto_mode ? learned_gradient : cfg.manual_velocity_gradient;
        // zero interval means standstill; a divide here would be meaningless
        if (step_interval_measure == 20'h00000) begin
            next_vel_term = 16'h0000;
        end else begin
            next_vel_term = 16'((20'(grad_used) << vpr_pkg::VEL_SHIFT) / step_interval_measure);  // RQ12
        end
        sum = 20'(ofs_used) + 20'(vel_term) + (auto_mode ? 20'(scale_auto) : 20'sh0);
        if (freewheel_zero) begin
            next_total = 8'h00;  // RQ7
        end else if (vpr_pkg::clamp_u8(sum) < vpr_pkg::AMP_MIN_REG) begin
            next_total = vpr_pkg::AMP_MIN_REG;  // RQ7
        end else begin
            next_total = vpr_pkg::clamp_u8(sum);  // RQ20 RQ17
        end
        next_saturated = next_total == vpr_pkg::AMP_MAX;  // RQ17
        peak_prod      = 16'(total) * 16'(vpr_pkg::SINE_PEAK);
        next_peak      = peak_prod[15:8];  // RQ13
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state            <= VPR_ST_FF;
            scale_auto       <= 10'sh000;
            learned_offset   <= vpr_pkg::LEARN_OFS_RST;
            learned_gradient <= vpr_pkg::LEARN_GRAD_RST;
            fs_cnt           <= 3'h0;
            vel_term         <= 16'h0000;
            total            <= vpr_pkg::AMP_MIN_REG;
            peak             <= 8'h00;
            saturated        <= 1'b0;
        end else begin
            state            <= next_state;
            scale_auto       <= next_scale_auto;
            learned_offset   <= next_learned_offset;
            learned_gradient <= next_learned_gradient;
            fs_cnt           <= next_fs_cnt;
            vel_term         <= next_vel_term;
            total            <= next_total;
            peak             <= next_peak;
            saturated        <= next_saturated;
        end
    end

    always_comb begin
        status.total_drive_amplitude = total;
        status.learned_offset        = learned_offset;  // RQ14
        status.learned_gradient      = learned_gradient;  // RQ14
        status.sine_peak             = peak;
        status.amplitude_saturated   = saturated;
        status.regulating            = state != VPR_ST_FF;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_ff_quiet;
        state == VPR_ST_FF && step_interval_measure == 20'h00000 && !freewheel_zero;
    endsequence

    a_auto_mode_entry: assert property ((state != VPR_ST_FF) |-> $past(cfg.autoscale_en && cfg.autograd_en)) // RQ1
        else $error("regulation active without both automatic enables");
    a_reg_raises: assert property (state == VPR_ST_REG && next_state == VPR_ST_REG && sample_stb && delta > 10'sh0
        && scale_auto < vpr_pkg::SCALE_POS_MAX |=> scale_auto > $past(scale_auto)) // RQ2
        else $error("positive error did not raise learned amplitude");
    a_ff_no_loop: assert property (state == VPR_ST_FF |=> scale_auto == 10'sh000) // RQ10
        else $error("feedback active in velocity mode");
    a_ff_formula: assert property (s_ff_quiet ##1 s_ff_quiet ##1 (s_ff_quiet and $stable(cfg))
        |-> total == ((cfg.manual_amplitude_offset == 8'h00) ? vpr_pkg::AMP_MIN_REG : cfg.manual_amplitude_offset)) // RQ12
        else $error("velocity mode total differs from offset at standstill");
    a_freewheel_zero: assert property (freewheel_zero |=> total == 8'h00) // RQ7
        else $error("freewheel did not give zero amplitude");
    a_floor_nonzero: assert property (!freewheel_zero |=> total != 8'h00) // RQ7
        else $error("regulated amplitude reached zero");
    a_sat_flag: assert property (saturated == (total == vpr_pkg::AMP_MAX)) // RQ17
        else $error("saturation flag disagrees with amplitude");
    a_sine_peak: assert property (##1 peak == 8'((16'($past(total)) * 16'(vpr_pkg::SINE_PEAK)) >> 8)) // RQ13
        else $error("sine peak not amplitude times 248/256");
    a_grad_learn: assert property (state == VPR_ST_PH2 && fullstep_pulse && fs_cnt == vpr_pkg::FS_PER_GRAD
        && scale_auto > 10'sh0 && learned_gradient != vpr_pkg::AMP_MAX |=> learned_gradient == $past(learned_gradient) + 8'h01) // RQ3
        else $error("gradient did not follow positive residual");
    a_grad_fall: assert property (state == VPR_ST_PH2 && fullstep_pulse && fs_cnt == vpr_pkg::FS_PER_GRAD // RQ3
        && scale_auto < 10'sh0 && learned_gradient != 8'h00
        |=> learned_gradient == $past(learned_gradient) - 8'h01)
        else $error("gradient did not follow negative residual");
    a_ofs_learn: assert property (state == VPR_ST_PH1 && sample_stb && delta < 10'sh0 && learned_offset != 8'h00
        |=> learned_offset == $past(learned_offset) - 8'h01) // RQ6
        else $error("offset did not follow negative error");

endmodule

// File: testbench/vpr_coil_model.sv
// behavioural coil: the shunt current follows the drive amplitude only while the bridge is on
`timescale 1ns/1ps
module vpr_coil_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       pwm_on,
    input  wire logic [7:0] drive_amplitude,
    output logic [7:0]      coil_current
);
    logic [7:0] last_current;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_current <= 8'h00;
        end else if (pwm_on) begin
            last_current <= {1'b0, drive_amplitude[7:1]};
        end
    end

    // off phase shows the inverse of the last value, so a stray sample there is caught
    assign coil_current = pwm_on ? {1'b0, drive_amplitude[7:1]} : ~last_current;
endmodule

// File: testbench/vpr_regulator_tb_top.sv
// self-checking bench for the voltage-mode amplitude regulator
`timescale 1ns/1ps
module vpr_regulator_tb_top;
    logic                 core_clk;
    logic                 rst_n;
    vpr_pkg::vpr_cfg_t    cfg;
    logic [7:0]           target_current;
    logic [7:0]           coil_current;
    logic [19:0]          step_interval_measure;
    logic                 tuning_phase_one;
    logic                 tuning_phase_two;
    logic                 fullstep_pulse;
    logic                 pwm_on;
    vpr_pkg::vpr_status_t status;
    int                   fails;
    int                   samples_checked;

    vpr_regulator i_dut (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .cfg                   (cfg),
        .target_current        (target_current),
        .coil_current          (coil_current),
        .step_interval_measure (step_interval_measure),
        .tuning_phase_one      (tuning_phase_one),
        .tuning_phase_two      (tuning_phase_two),
        .fullstep_pulse        (fullstep_pulse),
        .pwm_on                (pwm_on),
        .status                (status)
    );

    vpr_coil_model i_coil (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .pwm_on          (pwm_on),
        .drive_amplitude (status.total_drive_amplitude),
        .coil_current    (coil_current)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_cond(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic test_reset_values;
        check_val(status.learned_offset, 8'h24, "learned offset after reset");
        check_val(status.learned_gradient, 8'h0E, "learned gradient after reset");
        check_val(status.total_drive_amplitude, 8'h01, "total after reset");
        check_cond(status.regulating === 1'b0 && status.amplitude_saturated === 1'b0, "flags after reset");
    endtask

    task automatic test_manual_offset;
        logic [7:0] ofs [3] = '{8'h40, 8'h80, 8'hFF};
        for (int i = 0; i < 3; i++) begin
            cfg.manual_amplitude_offset = ofs[i];
            tick(4);
            check_val(status.total_drive_amplitude, ofs[i], "manual total");
            check_val(status.sine_peak, 8'((int'(ofs[i]) * 248) >> 8), "sine peak");
        end
    endtask

    task automatic test_velocity;
        int ofs [4] = '{32, 32, 16, 128};
        int grd [4] = '{16, 16, 3, 255};
        int itv [4] = '{256, 128, 768, 1};
        int raw;
        for (int i = 0; i < 4; i++) begin
            cfg.manual_amplitude_offset = 8'(ofs[i]);
            cfg.manual_velocity_gradient = 8'(grd[i]);
            step_interval_measure = 20'(itv[i]);
            tick(5);
            raw = ofs[i] + grd[i] * 256 / itv[i];
            check_val(status.total_drive_amplitude, 8'(raw > 255 ? 255 : raw), "velocity total");
            check_cond(status.amplitude_saturated === (raw > 255), "saturation flag");
        end
        cfg.manual_velocity_gradient = 8'h00;
        step_interval_measure = 20'h00000;
    endtask

    task automatic test_floor_freewheel;
        cfg.manual_amplitude_offset = 8'h00;
        target_current = 8'h10;
        tick(4);
        check_val(status.total_drive_amplitude, 8'h01, "regulated floor");
        cfg.freewheel_en = 1'b1;
        target_current = 8'h00;
        tick(4);
        check_val(status.total_drive_amplitude, 8'h00, "freewheel zero");
        cfg.freewheel_en = 1'b0;
        tick(4);
        check_val(status.total_drive_amplitude, 8'h01, "floor without freewheel");
    endtask

    task automatic test_chop_freq;
        int n [4] = '{1024, 683, 512, 410};
        int cnt;
        int edges;
        logic prev;
        cfg.manual_amplitude_offset = 8'h80;
        for (int c = 0; c < 4; c++) begin
            cfg.chopper_frequency_select = 2'(c);
            tick(600);
            cnt = 0;
            edges = 0;
            prev = pwm_on;
            for (int t = 0; t < 1200 && edges < 2; t++) begin
                tick(1);
                if (edges == 1) cnt++;
                if (pwm_on && !prev) edges++;
                prev = pwm_on;
            end
            check_cond(edges == 2 && cnt * 2 >= n[c] - 2 && cnt * 2 <= n[c] + 2, "chopper period");
        end
    endtask

    task automatic test_auto_regulation;
        logic [7:0] start;
        cfg.autoscale_en = 1'b1;
        cfg.autograd_en = 1'b1;
        cfg.regulator_gain = 8'h01;
        cfg.chopper_frequency_select = 2'h3;
        step_interval_measure = 20'h00000;
        target_current = 8'h60;
        tuning_phase_one = 1'b1;
        tick(2);
        check_cond(status.regulating === 1'b1, "regulating in automatic mode");
        start = status.learned_offset;
        tick(205 * 5);
        // one learning step per chopper period at most
        check_cond(status.learned_offset !== start && status.learned_offset <= start + 8'h06, "learn rate");
        // one step per period: 36 up to about 178 needs some 142 periods
        tick(205 * 160);
        check_cond(status.total_drive_amplitude inside {[8'hB0:8'hC2]}, "converged amplitude");
        target_current = 8'h30;
        tick(205 * 100);
        check_cond(status.total_drive_amplitude inside {[8'h50:8'h62]}, "follows lower target");
    endtask

    task automatic test_phase_two;
        logic [7:0] g;
        tuning_phase_one = 1'b0;
        tuning_phase_two = 1'b1;
        step_interval_measure = 20'h00200;
        // let the state reach phase two so all eight pulses are counted
        tick(1);
        g = status.learned_gradient;
        for (int i = 0; i < 8; i++) begin
            fullstep_pulse = 1'b1;
            tick(1);
            fullstep_pulse = 1'b0;
            tick(60);
        end
        // amplitude sits above twice the target, so the residual is negative
        check_val(status.learned_gradient, g - 8'h01, "gradient step per 8 fullsteps");
        tuning_phase_two = 1'b0;
    endtask

    task automatic test_run_tracking;
        target_current = 8'h40;
        tick(205 * 40);
        // coil shows half the amplitude; loop settles where the error drops below 8
        check_val(status.total_drive_amplitude, 8'h72, "run regulation amplitude");
        check_cond(status.regulating === 1'b1, "regulating after tuning");
    endtask

    initial begin
        #900000;
        fails++;
        print_verdict();
    end

    initial begin
        fails = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        cfg = '0;
        target_current = 8'h00;
        step_interval_measure = 20'h00000;
        tuning_phase_one = 1'b0;
        tuning_phase_two = 1'b0;
        fullstep_pulse = 1'b0;
        tick(5);
        rst_n = 1'b1;
        tick(1);
        test_reset_values();
        test_manual_offset();
        test_velocity();
        test_floor_freewheel();
        test_chop_freq();
        test_auto_regulation();
        test_phase_two();
        test_run_tracking();
        print_verdict();
    end
endmodule
